// file: hw/mca_pkg.sv
// Package for the monitor configuration bank and port arbiter.
// Assumes one system clock; JTAG signals arrive from another clock domain.
package mca_pkg;
    localparam int          DW             = 16;
    localparam int          AW             = 10;
    localparam int          NREG           = 5;
    localparam logic [9:0]  OFS_CHAN       = 10'h040;
    localparam logic [9:0]  OFS_ALARM_SEQ  = 10'h041;
    localparam logic [9:0]  OFS_CLKDIV     = 10'h042;
    localparam logic [9:0]  OFS_SERIAL     = 10'h043;
    localparam logic [9:0]  OFS_SLOW       = 10'h044;
    // Writable bits and reset values per register
    localparam logic [15:0] MASK_R0        = 16'hbf3f;
    localparam logic [15:0] MASK_R1        = 16'hffdf;
    localparam logic [15:0] MASK_R2        = 16'hff00;
    localparam logic [15:0] MASK_R3        = 16'hff8f;
    localparam logic [15:0] MASK_R4        = 16'h0f0f;
    localparam logic [15:0] RST_R0         = 16'h0000;
    localparam logic [15:0] RST_R1         = 16'h0000;
    localparam logic [15:0] RST_R2         = 16'h0000;
    localparam logic [15:0] RST_R3         = 16'h0000;
    localparam logic [15:0] RST_R4         = 16'h0c00;
    // Field positions
    localparam int          CH_LSB = 0, ACQ_BIT = 8, EC_BIT = 9, BU_BIT = 10, MUX_BIT = 11;
    localparam int          AVG_LSB = 12, COEFFICIENT_MEAN_DISABLE_BIT = 15;
    localparam int          OT_BIT = 0, ALM_LO_LSB = 1, CAL_LSB = 4, ALM_HI_LSB = 8, SEQ_LSB = 12;
    localparam int          CD_LSB = 8;
    localparam int          ALM_X_LSB = 0, TWI_EN_BIT = 7, TWI_A_LSB = 8, TWI_OR_BIT = 15;
    localparam int          PMBUS_SEL_BIT = 10;
    localparam int          LRD_LSB = 8, EOS_LSB = 10;
    // Channel codes
    localparam logic [5:0]  CH_CAL         = 6'h08;
    localparam logic [5:0]  CH_BAD7        = 6'h07;
    localparam logic [5:0]  CH_BAD_LO      = 6'h09;
    localparam logic [5:0]  CH_BAD_HI      = 6'h0c;
    localparam logic [5:0]  CH_LIMIT       = 6'h24;
    // Converter timing
    localparam logic [3:0]  ACQ_SHORT      = 4'h4;
    localparam logic [3:0]  ACQ_LONG       = 4'ha;
    localparam logic [4:0]  COEF_MEAN      = 5'h10;
    localparam logic [7:0]  DIV_MIN        = 8'h02;
    localparam logic [6:0]  TWI_ADDR_DFLT  = 7'h38;
    // JTAG scan register
    localparam logic [5:0]  INSTR_SHORT    = 6'h37;
    localparam logic [11:0] INSTR_LONG     = 12'hff7;
    localparam int          DR_W           = 32;
    localparam int          DR_ADDR_LSB    = 16;
    localparam int          DR_CMD_LSB     = 26;
    localparam logic [3:0]  CMD_READ       = 4'h1;
    localparam logic [3:0]  CMD_WRITE      = 4'h2;
    localparam logic [1:0]  JPOL_ENABLE    = 2'h0;
    localparam logic [1:0]  JPOL_READONLY  = 2'h1;
    localparam logic [1:0]  JPOL_DISABLE   = 2'h2;
    localparam int          JTAG_LIMIT_CYC = 18;

    typedef enum logic [1:0] {SCAN_DEFAULT, SCAN_ONE_PASS, SCAN_CONT, SCAN_SINGLE} mca_scan_e;
    typedef enum logic [1:0] {ARB_IDLE, ARB_XFER} mca_arb_e;
    typedef enum logic [1:0] {SRC_FAB, SRC_TWI, SRC_JTAG} mca_src_e;

    typedef struct packed {
        logic          valid;
        logic          write;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } mca_req_s;
endpackage

// file: hw/mca_bank.sv
// Monitor configuration registers with a per-transaction port arbiter.
// Fabric and two-wire requests are on clk_sys_i; JTAG TAP signals are foreign.
`timescale 1ns/1ps
// Function
// - Channel field picks the input; in single-channel or external multiplexer mode code 8 calibrates, 7, 9-12, 36+ invalid.
// - Settle bit gives 4 or 10 converter cycles; fixed in default mode.
// - Polarity bit selects unipolar or bipolar in single-channel mode.
// - Trigger bit selects continuous or event-driven sampling.
// - External selector bit enables external multiplexer mode.
// - Averaging field: none, 16, 64 or 256 samples.
// - Coefficient averaging over 16 samples unless disable bit is set.
// - Overheat disable bit suppresses the overheat output.
// - Each alert disable bit suppresses its alarm output.
// - Scan mode: default, one pass, continuous, single; upper bits set gives default.
// - Correction bits 0, 2, 3 enable offsets and gain; bit 1 kept zero.
// - Converter clock is port clock over ratio, minimum two.
// - Two-wire enable bit permits two-wire access after configuration.
// - Override bit uses programmed two-wire address, else fixed 38h.
// - Address bit 2 selects PMBus or plain I2C when the override bit is set.
// - Low-rate channels converted every 1, 4, 16 or 64 sequences.
// - End marker from main list, low-rate list, or both.
// - Arbiter serves fabric, two-wire and JTAG one transaction at a time.
// - Access instruction 110111 or FF7h selects 32-bit scan register.
// - Update-DR hands command to arbiter; write done within 18 cycles.
// - Configuration setting makes JTAG access read-only or blocked.
// - Registers writable through the port at any time.
// - Channel 8 computes coefficients in single-channel or external multiplexer mode; default mode corrects automatically.
module mca_bank
    import mca_pkg::*;
#(
    parameter bit PS_VARIANT = 1'b0
) (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire mca_req_s    dcp_req_i,
    output logic [15:0]      dcp_rdata_o,
    output logic             dcp_rdy_o,
    input  wire mca_req_s    twi_req_i,
    output logic [15:0]      twi_rdata_o,
    output logic             twi_ack_o,
    input  wire logic        jtag_tck_i,
    input  wire logic        jtag_tdi_i,
    input  wire logic [11:0] jtag_ir_i,
    input  wire logic        jtag_capture_i,
    input  wire logic        jtag_shift_i,
    input  wire logic        jtag_update_i,
    input  wire logic [1:0]  jtag_policy_i,
    output logic             jtag_tdo_o,
    output logic             jtag_readonly_o,
    output logic             jtag_disabled_o,
    input  wire logic [11:0] alarm_raw_i,
    input  wire logic        main_list_end_i,
    input  wire logic        low_list_end_i,
    output logic [11:0]      alarm_o,
    output logic [5:0]       conv_channel_o,
    output logic             chan_invalid_o,
    output logic             cal_run_o,
    output logic [3:0]       acq_cycles_o,
    output logic             bipolar_o,
    output logic             event_trigger_o,
    output logic             ext_mux_o,
    output logic [8:0]       mean_count_o,
    output logic [4:0]       coef_mean_o,
    output mca_scan_e        scan_mode_o,
    output logic [3:0]       corr_enable_o,
    output logic             conv_clk_en_o,
    output logic             twi_enable_o,
    output logic [6:0]       twi_addr_o,
    output logic             pmbus_sel_o,
    output logic             low_rate_due_o,
    output logic             end_of_scan_o
);
    logic [15:0] cfg_q [NREG];
    mca_arb_e    arb_q;
    mca_src_e    grant_q;
    mca_req_s    fab_q, twi_q, jreq_q;
    logic [15:0] dcp_rdata_q, twi_rdata_q, jrdata_q;
    logic        dcp_rdy_q, twi_ack_q;
    logic [3:0]  tck_s_q;
    logic [1:0]  tdi_s_q, cap_s_q, sh_s_q, up_s_q;
    logic [1:0]  pol_s_q, pol_q;
    logic [23:0] ir_s_q;
    logic        pol_taken_q;
    logic [31:0] dr_q;
    logic [7:0]  div_cnt_q;
    logic [5:0]  seq_cnt_q;
    logic [11:0] alarm_q;
    logic        clk_en_q, due_q, eos_q;

    function automatic logic [2:0] reg_index(input logic [9:0] a);
        return 3'(a - OFS_CHAN);
    endfunction
    function automatic logic is_cfg(input logic [9:0] a);
        return (a >= OFS_CHAN) && (a <= OFS_SLOW);
    endfunction
    function automatic logic [15:0] reg_mask(input logic [2:0] i);
        unique case (i)
            3'h0:    return MASK_R0;
            3'h1:    return MASK_R1;
            3'h2:    return MASK_R2;
            3'h3:    return MASK_R3;
            default: return MASK_R4;
        endcase
    endfunction

    // Arbitration selection: current transaction finishes, JTAG then fabric then two-wire
    mca_req_s    cur_req;
    wire         any_pend  = fab_q.valid | twi_q.valid | jreq_q.valid;
    wire         cur_hit   = is_cfg(cur_req.addr);
    wire [2:0]   cur_idx   = reg_index(cur_req.addr);
    wire [15:0]  cur_rdata = cur_hit ? cfg_q[cur_idx] : 16'h0000;
    assign cur_req = (grant_q == SRC_JTAG) ? jreq_q : (grant_q == SRC_TWI) ? twi_q : fab_q;

    // JTAG instruction match, command decode and TCK edge
    wire         tck_rise  = tck_s_q[2] & ~tck_s_q[3];
    wire [11:0]  ir_now    = ir_s_q[23:12];
    wire         ir_match  = PS_VARIANT ? (ir_now == INSTR_LONG)
                                        : (ir_now[5:0] == INSTR_SHORT);
    wire [3:0]   dr_cmd    = dr_q[DR_CMD_LSB +: 4];
    wire         j_blocked = (pol_q == JPOL_DISABLE);
    wire         j_wr_ok   = (pol_q == JPOL_ENABLE);
    wire         j_issue   = tck_rise & up_s_q[1] & ir_match & ~j_blocked & pol_taken_q &
                             ((dr_cmd == CMD_READ) | ((dr_cmd == CMD_WRITE) & j_wr_ok));

    // Decoded configuration
    wire [15:0]  r0 = cfg_q[0];
    wire [15:0]  r1 = cfg_q[1];
    wire [15:0]  r2 = cfg_q[2];
    wire [15:0]  r3 = cfg_q[3];
    wire [15:0]  r4 = cfg_q[4];
    wire [3:0]   seq_f     = r1[SEQ_LSB +: 4];
    wire [5:0]   ch_f      = r0[CH_LSB +: 6];
    mca_scan_e   mode_d;
    assign mode_d = (seq_f[3:2] == 2'b11 || seq_f == 4'h0) ? SCAN_DEFAULT :
                    (seq_f == 4'h1) ? SCAN_ONE_PASS :
                    (seq_f == 4'h2) ? SCAN_CONT : SCAN_SINGLE;
    wire         sel_mode  = (mode_d == SCAN_SINGLE) | r0[MUX_BIT];
    wire         ch_bad    = (ch_f == CH_BAD7) | (ch_f >= CH_BAD_LO && ch_f <= CH_BAD_HI) |
                             (ch_f >= CH_LIMIT);
    wire [1:0]   avg_f     = r0[AVG_LSB +: 2];
    wire [8:0]   mean_d    = (avg_f == 2'h0) ? 9'h001 : (avg_f == 2'h1) ? 9'h010 :
                             (avg_f == 2'h2) ? 9'h040 : 9'h100;
    wire [3:0]   cal_f     = r1[CAL_LSB +: 4];
    wire [3:0]   corr_d    = (mode_d == SCAN_DEFAULT) ? 4'hd : (cal_f & 4'hd);
    wire [7:0]   cd_f      = r2[CD_LSB +: 8];
    wire [7:0]   ratio     = (cd_f < DIV_MIN) ? DIV_MIN : cd_f;
    wire [11:0]  alm_dis   = {r3[ALM_X_LSB +: 4], r1[OT_BIT], r1[ALM_HI_LSB +: 4],
                              r1[ALM_LO_LSB +: 3]};
    wire [1:0]   lrd_f     = r4[LRD_LSB +: 2];
    wire [5:0]   lr_mask   = (lrd_f == 2'h0) ? 6'h00 : (lrd_f == 2'h1) ? 6'h03 :
                             (lrd_f == 2'h2) ? 6'h0f : 6'h3f;
    wire [1:0]   eos_f     = r4[EOS_LSB +: 2];
    wire         eos_d     = (eos_f == 2'h1) ? low_list_end_i :
                             (eos_f == 2'h2) ? (main_list_end_i | low_list_end_i)
                                             : main_list_end_i;

    // Request latches and arbiter
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            arb_q     <= ARB_IDLE;
            grant_q   <= SRC_FAB;
            fab_q     <= '0;
            twi_q     <= '0;
            jreq_q    <= '0;
            dcp_rdy_q <= 1'b0;
            twi_ack_q <= 1'b0;
        end else begin
            dcp_rdy_q <= 1'b0;
            twi_ack_q <= 1'b0;
            if (dcp_req_i.valid && !fab_q.valid) fab_q <= dcp_req_i;
            if (twi_req_i.valid && !twi_q.valid && r3[TWI_EN_BIT]) twi_q <= twi_req_i;
            if (j_issue && !jreq_q.valid) begin
                jreq_q <= '{valid: 1'b1, write: dr_cmd == CMD_WRITE,
                            addr: dr_q[DR_ADDR_LSB +: AW], data: dr_q[15:0]};
            end
            unique case (arb_q)
                ARB_IDLE: begin
                    if (any_pend) begin
                        arb_q   <= ARB_XFER;
                        grant_q <= jreq_q.valid ? SRC_JTAG : fab_q.valid ? SRC_FAB : SRC_TWI;
                    end
                end
                ARB_XFER: begin
                    arb_q <= ARB_IDLE;
                    unique case (grant_q)
                        SRC_JTAG: jreq_q.valid <= 1'b0;
                        SRC_TWI:  begin twi_q.valid <= 1'b0; twi_ack_q <= 1'b1; end
                        default:  begin fab_q.valid <= 1'b0; dcp_rdy_q <= 1'b1; end
                    endcase
                end
                default: arb_q <= ARB_IDLE;
            endcase
        end
    end

    // Register file and read data
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_q       <= '{RST_R0, RST_R1, RST_R2, RST_R3, RST_R4};
            dcp_rdata_q <= 16'h0000;
            twi_rdata_q <= 16'h0000;
            jrdata_q    <= 16'h0000;
        end else if (arb_q == ARB_XFER) begin
            if (cur_req.write && cur_hit) cfg_q[cur_idx] <= cur_req.data & reg_mask(cur_idx);
            unique case (grant_q)
                SRC_JTAG: if (!cur_req.write) jrdata_q <= cur_rdata;
                SRC_TWI:  twi_rdata_q <= cur_rdata;
                default:  dcp_rdata_q <= cur_rdata;
            endcase
        end
    end

    // JTAG synchronisers, policy capture and scan register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tck_s_q     <= 4'h0;
            tdi_s_q     <= 2'h0;
            cap_s_q     <= 2'h0;
            sh_s_q      <= 2'h0;
            up_s_q      <= 2'h0;
            ir_s_q      <= 24'h000000;
            pol_s_q     <= jtag_policy_i;
            pol_q       <= JPOL_DISABLE;
            pol_taken_q <= 1'b0;
            dr_q        <= 32'h00000000;
        end else begin
            tck_s_q <= {tck_s_q[2:0], jtag_tck_i};
            tdi_s_q <= {tdi_s_q[0], jtag_tdi_i};
            cap_s_q <= {cap_s_q[0], jtag_capture_i};
            sh_s_q  <= {sh_s_q[0], jtag_shift_i};
            up_s_q  <= {up_s_q[0], jtag_update_i};
            ir_s_q  <= {ir_s_q[11:0], jtag_ir_i};
            pol_s_q <= jtag_policy_i;
            if (!pol_taken_q) begin
                pol_q       <= pol_s_q;
                pol_taken_q <= 1'b1;
            end
            if (tck_rise && ir_match && !j_blocked) begin
                if (cap_s_q[1]) dr_q <= {16'h0000, jrdata_q};
                else if (sh_s_q[1]) dr_q <= {tdi_s_q[1], dr_q[DR_W-1:1]};
            end
        end
    end

    // Converter side outputs
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            div_cnt_q <= 8'h00;
            clk_en_q  <= 1'b0;
            seq_cnt_q <= 6'h00;
            due_q     <= 1'b0;
            eos_q     <= 1'b0;
            alarm_q   <= 12'h000;
        end else begin
            clk_en_q <= (div_cnt_q >= ratio - 8'h01);
            div_cnt_q <= (div_cnt_q >= ratio - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
            if (main_list_end_i) begin
                seq_cnt_q <= seq_cnt_q + 6'h01;
                due_q     <= ((seq_cnt_q & lr_mask) == 6'h00);
            end
            eos_q   <= eos_d;
            alarm_q <= alarm_raw_i & ~alm_dis;
        end
    end

    assign dcp_rdata_o     = dcp_rdata_q;
    assign dcp_rdy_o       = dcp_rdy_q;
    assign twi_rdata_o     = twi_rdata_q;
    assign twi_ack_o       = twi_ack_q;
    assign jtag_tdo_o      = dr_q[0];
    assign jtag_readonly_o = (pol_q == JPOL_READONLY);
    assign jtag_disabled_o = (pol_q == JPOL_DISABLE);
    assign alarm_o         = alarm_q;
    assign conv_channel_o  = ch_f;
    assign chan_invalid_o  = sel_mode & ch_bad;
    assign cal_run_o       = sel_mode & (ch_f == CH_CAL);
    assign acq_cycles_o    = (mode_d != SCAN_DEFAULT && r0[ACQ_BIT]) ? ACQ_LONG : ACQ_SHORT;
    assign bipolar_o       = (mode_d == SCAN_SINGLE) & r0[BU_BIT];
    assign event_trigger_o = r0[EC_BIT];
    assign ext_mux_o       = r0[MUX_BIT];
    assign mean_count_o    = mean_d;
    assign coef_mean_o     = r0[COEFFICIENT_MEAN_DISABLE_BIT] ? 5'h01 : COEF_MEAN;
    assign scan_mode_o     = mode_d;
    assign corr_enable_o   = corr_d;
    assign conv_clk_en_o   = clk_en_q;
    assign twi_enable_o    = r3[TWI_EN_BIT];
    assign twi_addr_o      = r3[TWI_OR_BIT] ? r3[TWI_A_LSB +: 7] : TWI_ADDR_DFLT;
    assign pmbus_sel_o     = r3[TWI_OR_BIT] & r3[PMBUS_SEL_BIT];
    assign low_rate_due_o  = due_q;
    assign end_of_scan_o   = eos_q;

    // Checks
    int unsigned j_wait_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || !jreq_q.valid) j_wait_q <= 0;
        else j_wait_q <= j_wait_q + 1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_fab_taken;
        arb_q == ARB_XFER && grant_q == SRC_FAB;
    endsequence
    sequence s_fab_done;
        dcp_rdy_o && !fab_q.valid;
    endsequence
    a_jtag_write_bound: assert property (j_wait_q < JTAG_LIMIT_CYC)
        else $error("JTAG transaction waited too long");
    a_one_grant_only: assert property (arb_q == ARB_XFER |=> arb_q == ARB_IDLE)
        else $error("Arbiter held a grant longer than one transaction");
    a_fab_answer_after: assert property (s_fab_taken |=> s_fab_done)
        else $error("Fabric answer missing after transfer");
    a_jtag_priority_grant: assert property (arb_q == ARB_IDLE && jreq_q.valid
        |=> grant_q == SRC_JTAG)
        else $error("Pending JTAG command not granted first");
    a_readonly_no_write: assert property (pol_q != JPOL_ENABLE |-> !(jreq_q.valid && jreq_q.write))
        else $error("JTAG write accepted under restricted policy");
    a_div_pulse_gap: assert property ($rose(conv_clk_en_o) |=> !conv_clk_en_o)
        else $error("Converter clock enable held two cycles");
    a_alarm_masked: assert property (alm_dis[7] |=> !alarm_o[7] || $changed(r1))
        else $error("Overheat output not suppressed");
    a_cal_bit1_zero: assert property (corr_enable_o[1] == 1'b0)
        else $error("Correction bit 1 driven");
    a_acq_default_fixed: assert property (scan_mode_o == SCAN_DEFAULT |-> acq_cycles_o == ACQ_SHORT)
        else $error("Acquisition time adjusted in default mode");
endmodule

// file: bench/mca_tap_model.sv
// JTAG host model: holds the access instruction and runs 32-bit data scans.
// Assumes the bank samples these lines with its own clock.
`timescale 1ns/1ps
module mca_tap_model
    import mca_pkg::*;
#(
    parameter int HALF = 160
) (
    output logic        tck_o,
    output logic        tdi_o,
    output logic        cap_o,
    output logic        shift_o,
    output logic        upd_o,
    output logic [11:0] ir_o,
    input  logic        tdo_i
);
    logic [31:0] rx_word;
    initial begin
        {tck_o, tdi_o, cap_o, shift_o, upd_o} = '0;
        ir_o = {6'h00, INSTR_SHORT};
    end
    task automatic tick();
        #HALF tck_o = 1'b1;
        #HALF tck_o = 1'b0;
    endtask
    // Capture, 32 shifts LSB first, update; clock stands still between frames
    task automatic scan(input logic [31:0] w);
        cap_o = 1'b1;
        tick();
        cap_o   = 1'b0;
        shift_o = 1'b1;
        for (int i = 0; i < DR_W; i++) begin
            tdi_o = w[i];
            rx_word[i] = tdo_i;
            tick();
        end
        shift_o = 1'b0;
        tdi_o   = ~tdi_o;
        upd_o   = 1'b1;
        tick();
        upd_o = 1'b0;
    endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the monitor configuration bank.
// Assumes mca_pkg and mca_bank are compiled first.
`timescale 1ns/1ps
module tb_top;
    import mca_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    mca_req_s    dcp_req_i = '0, twi_req_i = '0;
    logic [15:0] dcp_rdata_o, twi_rdata_o, rd;
    logic        dcp_rdy_o, twi_ack_o, jtag_tdo_o, jtag_readonly_o, jtag_disabled_o;
    logic        jtag_tck_i, jtag_tdi_i, jtag_capture_i, jtag_shift_i, jtag_update_i;
    logic [11:0] jtag_ir_i, alarm_o;
    logic [11:0] alarm_raw_i = 12'hfff;
    logic [1:0]  jtag_policy_i = 2'h0;
    logic        main_list_end_i = 1'b0, low_list_end_i = 1'b0;
    logic [5:0]  conv_channel_o;
    logic        chan_invalid_o, cal_run_o, bipolar_o, event_trigger_o, ext_mux_o;
    logic [3:0]  acq_cycles_o, corr_enable_o;
    logic [8:0]  mean_count_o;
    logic [4:0]  coef_mean_o;
    mca_scan_e   scan_mode_o;
    logic        conv_clk_en_o, twi_enable_o, pmbus_sel_o, low_rate_due_o, end_of_scan_o;
    logic [6:0]  twi_addr_o;
    bit          got;
    int          error_cnt = 0, checked = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    mca_tap_model TAP (.tck_o(jtag_tck_i), .tdi_o(jtag_tdi_i), .cap_o(jtag_capture_i),
        .shift_o(jtag_shift_i), .upd_o(jtag_update_i), .ir_o(jtag_ir_i), .tdo_i(jtag_tdo_o));
    mca_bank #(.PS_VARIANT(1'b0)) DUT (.clk_sys_i, .nrst_i, .dcp_req_i, .dcp_rdata_o,
        .dcp_rdy_o, .twi_req_i, .twi_rdata_o, .twi_ack_o, .jtag_tck_i, .jtag_tdi_i,
        .jtag_ir_i, .jtag_capture_i, .jtag_shift_i, .jtag_update_i, .jtag_policy_i,
        .jtag_tdo_o, .jtag_readonly_o, .jtag_disabled_o, .alarm_raw_i, .main_list_end_i,
        .low_list_end_i, .alarm_o, .conv_channel_o, .chan_invalid_o, .cal_run_o,
        .acq_cycles_o, .bipolar_o, .event_trigger_o, .ext_mux_o, .mean_count_o,
        .coef_mean_o, .scan_mode_o, .corr_enable_o, .conv_clk_en_o, .twi_enable_o,
        .twi_addr_o, .pmbus_sel_o, .low_rate_due_o, .end_of_scan_o);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One transfer on fabric or two-wire port; leaves got and rd
    task automatic acc(input bit twi, input bit wr, input logic [9:0] a, input logic [15:0] d);
        mca_req_s r;
        r = '{1'b1, wr, a, d};
        got = 1'b0;
        if (twi) twi_req_i = r;
        else dcp_req_i = r;
        @(negedge clk_sys_i);
        twi_req_i.valid = 1'b0;
        dcp_req_i.valid = 1'b0;
        for (int n = 0; n < 12 && !got; n++) begin
            if ((twi ? twi_ack_o : dcp_rdy_o) === 1'b1) begin
                got = 1'b1;
                rd  = twi ? twi_rdata_o : dcp_rdata_o;
            end
            @(negedge clk_sys_i);
        end
    endtask
    task automatic rw(input bit wr, input logic [9:0] a, input logic [15:0] d);
        acc(1'b0, wr, a, d);
        if (!got) begin
            chk("fabric_done", 0, 1);
            tally_and_finish();
        end
    endtask
    task automatic do_reset(input logic [1:0] pol);
        jtag_policy_i = pol;
        nrst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic test_regs();
        logic [15:0] rst[5] = '{RST_R0, RST_R1, RST_R2, RST_R3, RST_R4};
        logic [15:0] msk[5] = '{MASK_R0, MASK_R1, MASK_R2, MASK_R3, MASK_R4};
        int n;
        chk("twi_addr", twi_addr_o, TWI_ADDR_DFLT);
        for (int i = 0; i < NREG; i++) begin
            rw(1'b0, 10'(OFS_CHAN + i), 16'h0);
            chk("reset_value", rd, rst[i]);
            rw(1'b1, 10'(OFS_CHAN + i), (i == 1) ? 16'hffdf : 16'hffff);
            rw(1'b0, 10'(OFS_CHAN + i), 16'h0);
            chk("masked_value", rd, msk[i]);
        end
        rw(1'b0, 10'h045, 16'h0);
        chk("unmapped", rd, 0);
        chk("twi_addr_or", twi_addr_o, 7'h7f);
        chk("pmbus", pmbus_sel_o, 1);
        chk("twi_en", twi_enable_o, 1);
        acc(1'b1, 1'b0, OFS_SERIAL, 16'h0);
        chk("twi_got", got, 1);
        chk("twi_read", rd, MASK_R3);
        dcp_req_i = '{1'b1, 1'b0, OFS_CHAN, 16'h0000};
        twi_req_i = '{1'b1, 1'b0, OFS_SERIAL, 16'h0000};
        @(negedge clk_sys_i);
        dcp_req_i.valid = 1'b0;
        twi_req_i.valid = 1'b0;
        for (n = 0; n < 12 && twi_ack_o !== 1'b1; n++) @(negedge clk_sys_i);
        chk("twi_after_fab", n, 4);
        rw(1'b1, OFS_SERIAL, 16'hbb00);
        chk("twi_addr_3b", twi_addr_o, 7'h3b);
        chk("pmbus_off", pmbus_sel_o, 0);
        acc(1'b1, 1'b0, OFS_SERIAL, 16'h0);
        chk("twi_refused", got, 0);
        $display("test regs done");
    endtask
    task automatic test_decode();
        logic [5:0] ch[7] = '{6'h03, 6'h07, 6'h08, 6'h09, 6'h0c, 6'h23, 6'h24};
        logic [3:0] sq[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'hf};
        mca_scan_e  sm[6] = '{SCAN_DEFAULT, SCAN_ONE_PASS, SCAN_CONT, SCAN_SINGLE,
                              SCAN_DEFAULT, SCAN_DEFAULT};
        for (int i = 0; i < 6; i++) begin
            rw(1'b1, OFS_ALARM_SEQ, {sq[i], 12'h0});
            chk("scan_mode", scan_mode_o, sm[i]);
        end
        rw(1'b1, OFS_ALARM_SEQ, 16'h3050);
        chk("corr_single", corr_enable_o, 4'h5);
        for (int i = 0; i < 7; i++) begin
            rw(1'b1, OFS_CHAN, {10'h0, ch[i]});
            chk("channel", conv_channel_o, ch[i]);
            chk("invalid", chan_invalid_o, !(i == 0 || i == 2 || i == 5));
            chk("cal_run", cal_run_o, i == 2);
        end
        for (int k = 0; k < 4; k++) begin
            rw(1'b1, OFS_CHAN, {k[0], 1'b0, k[1:0], k[0], k[1], k[0], k[1], 8'h03});
            chk("mean", mean_count_o, (k == 0) ? 1 : (16 << (2 * (k - 1))));
            chk("coef_mean", coef_mean_o, k[0] ? 1 : COEF_MEAN);
            chk("acq", acq_cycles_o, k[1] ? ACQ_LONG : ACQ_SHORT);
            chk("event", event_trigger_o, k[0]);
            chk("bipolar", bipolar_o, k[1]);
            chk("ext_mux", ext_mux_o, k[0]);
        end
        $display("test decode done");
    endtask
    task automatic test_alarm_clk();
        logic [7:0] cd[4] = '{8'h00, 8'h02, 8'h03, 8'hff};
        int n;
        rw(1'b1, OFS_ALARM_SEQ, 16'h3001);
        chk("alarm_ot", alarm_o, 12'hf7f);
        rw(1'b1, OFS_ALARM_SEQ, 16'h3a0a);
        rw(1'b1, OFS_SERIAL, 16'h0005);
        chk("alarm_mask", alarm_o, 12'haaa);
        for (int i = 0; i < 4; i++) begin
            rw(1'b1, OFS_CLKDIV, {cd[i], 8'h00});
            for (n = 0; n < 600 && conv_clk_en_o !== 1'b1; n++) @(negedge clk_sys_i);
            n = 0;
            do begin
                @(negedge clk_sys_i);
                n++;
            end while (conv_clk_en_o !== 1'b1 && n < 600);
            chk("div_period", n, (cd[i] < 3) ? 2 : cd[i]);
        end
        for (int s = 0; s < 4; s++) begin
            rw(1'b1, OFS_SLOW, {4'h0, s[1:0], 10'h0});
            for (int l = 0; l < 2; l++) begin
                {low_list_end_i, main_list_end_i} = l ? 2'b10 : 2'b01;
                @(negedge clk_sys_i);
                chk("end_of_scan", end_of_scan_o, l ? (s == 1 || s == 2) : (s != 1));
                {low_list_end_i, main_list_end_i} = 2'b00;
                @(negedge clk_sys_i);
                chk("end_of_scan_low", end_of_scan_o, 0);
            end
        end
        for (int s = 0; s < 4; s++) begin
            rw(1'b1, OFS_SLOW, {6'h0, s[1:0], 8'h00});
            n = 0;
            repeat (64) begin
                main_list_end_i = 1'b1;
                @(negedge clk_sys_i);
                main_list_end_i = 1'b0;
                @(negedge clk_sys_i);
                n += low_rate_due_o;
            end
            chk("low_rate_due", n, 64 >> (2 * s));
        end
        $display("test alarm and clock done");
    endtask
    task automatic test_jtag();
        for (int p = 0; p < 2; p++) begin
            do_reset(p[1:0]);
            chk("readonly", jtag_readonly_o, p);
            TAP.scan({2'b00, CMD_WRITE, OFS_CLKDIV, 16'h0500});
            repeat (JTAG_LIMIT_CYC + 6) @(negedge clk_sys_i);
            rw(1'b0, OFS_CLKDIV, 16'h0);
            chk("jtag_write", rd, p ? RST_R2 : 16'h0500);
            TAP.scan({2'b00, CMD_READ, OFS_CLKDIV, 16'h0000});
            repeat (JTAG_LIMIT_CYC + 6) @(negedge clk_sys_i);
            TAP.scan(32'h00000000);
            chk("jtag_read", TAP.rx_word, {16'h0000, p ? RST_R2 : 16'h0500});
        end
        do_reset(JPOL_DISABLE);
        chk("disabled", jtag_disabled_o, 1);
        $display("test jtag done");
    endtask
    initial begin
        do_reset(JPOL_ENABLE);
        test_regs();
        test_decode();
        test_alarm_clk();
        test_jtag();
        tally_and_finish();
    end
endmodule
